// [common/pca_pkg.sv]
package pca_pkg;
  localparam int          DATA_W        = 16;
  localparam int          ADDR_W        = 8;
  localparam int          SUM_W         = 32;
  localparam int          TIME_W        = 64;
  localparam int          LATCH_W       = 48;
  localparam logic [7:0]  OFS_RATE_LO   = 8'h04;
  localparam logic [7:0]  OFS_RATE_HI   = 8'h06;
  localparam logic [7:0]  OFS_SUM_LO    = 8'h08;
  localparam logic [7:0]  OFS_SUM_HI    = 8'h0A;
  localparam logic [7:0]  OFS_TIME_W0   = 8'h0C;
  localparam logic [7:0]  OFS_TIME_W1   = 8'h0E;
  localparam logic [7:0]  OFS_TIME_W2   = 8'h10;
  localparam logic [7:0]  OFS_TIME_W3   = 8'h12;
  localparam logic [15:0] WORD_RESET    = 16'h0000;
  localparam logic [15:0] READ_UNMAPPED = 16'h0000;
  localparam logic [31:0] SUM_RESET     = 32'h0000_0000;
  localparam logic [31:0] RATE_RESET    = 32'h0000_0000;
  localparam logic [47:0] LATCH_RESET   = 48'h0000_0000_0000;
  localparam logic [63:0] TIME_RESET    = 64'h0000_0000_0000_0000;
  localparam logic [63:0] TIME_STEP     = 64'h0000_0000_0000_0001;
endpackage

// [design/pca_time_counter.sv]
`timescale 1ns/100ps
`default_nettype none
module pca_time_counter
  import pca_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              countUp,
  input  wire logic              loadEn,
  input  wire logic [TIME_W-1:0] loadValue,
  input  wire logic              captureEn,
  output logic      [TIME_W-1:0] count,
  output logic     [LATCH_W-1:0] upperLatch
);
  logic [TIME_W-1:0]  next_count;
  logic [LATCH_W-1:0] next_upperLatch;
  logic [LATCH_W-1:0] countHi;

  assign countHi = count[TIME_W-1:16];

  // a load in the same cycle as a rollover wins: software sets time exactly
  always_comb begin
    next_count      = count;
    next_upperLatch = upperLatch;
    if (loadEn) begin
      next_count = loadValue;
    end else if (countUp) begin
      next_count = count + TIME_STEP;
    end
    if (captureEn) begin
      next_upperLatch = countHi;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      count      <= TIME_RESET;
      upperLatch <= LATCH_RESET;
    end else begin
      count      <= next_count;
      upperLatch <= next_upperLatch;
    end
  end

  time_step_a: assert property (@(posedge clk) disable iff (srst)
    !$past(srst) && $past(countUp) && !$past(loadEn)
      |-> count == $past(count) + TIME_STEP)
    else $error("local time did not advance on overflow");

  time_load_a: assert property (@(posedge clk) disable iff (srst)
    loadEn |=> count == $past(loadValue))
    else $error("local time not loaded by word3 write");

  time_latch_a: assert property (@(posedge clk) disable iff (srst)
    captureEn ##1 (!captureEn)[*2] |-> upperLatch == $past(countHi, 2))
    else $error("upper time bits not held after word0 read");
endmodule // pca_time_counter
`default_nettype wire

// [design/ptp_clock_accumulator.sv]
`timescale 1ns/100ps
`default_nettype none
module pca_clock_accumulator
  import pca_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWrData,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [DATA_W-1:0] regRdData,
  output logic                   overflowPulse,
  output logic      [TIME_W-1:0] localTime
);
  logic [SUM_W-1:0]   rateStep;
  logic [DATA_W-1:0]  rateStepLowHold;
  logic [SUM_W-1:0]   phaseSum;
  logic [DATA_W-1:0]  phaseSumLowHold;
  logic [DATA_W-1:0]  phaseSumHighLatch;
  logic [LATCH_W-1:0] timeWordHold;
  logic               checkReady;

  logic [SUM_W-1:0]   next_rateStep;
  logic [DATA_W-1:0]  next_rateStepLowHold;
  logic [SUM_W-1:0]   next_phaseSum;
  logic [DATA_W-1:0]  next_phaseSumLowHold;
  logic [DATA_W-1:0]  next_phaseSumHighLatch;
  logic [LATCH_W-1:0] next_timeWordHold;
  logic [DATA_W-1:0]  next_regRdData;
  logic               next_overflowPulse;

  logic [SUM_W:0]     sumWide;
  logic [DATA_W-1:0]  phaseHi;
  logic [DATA_W-1:0]  phaseLo;
  logic [LATCH_W-1:0] timeUpper;
  logic               rateHiWr;
  logic               accLoWr;
  logic               accHiWr;
  logic               accLoRd;
  logic               accHiRd;
  logic               timeLoRd;
  logic               timeHiWr;

  function automatic logic hit(input logic strobe,
                               input logic [ADDR_W-1:0] addr,
                               input logic [ADDR_W-1:0] ofs);
    hit = strobe && (addr == ofs);
  endfunction

  assign rateHiWr = hit(regWr, regAddr, OFS_RATE_HI);
  assign accLoWr  = hit(regWr, regAddr, OFS_SUM_LO);
  assign accHiWr  = hit(regWr, regAddr, OFS_SUM_HI);
  assign accLoRd  = hit(regRd, regAddr, OFS_SUM_LO);
  assign accHiRd  = hit(regRd, regAddr, OFS_SUM_HI);
  assign timeLoRd = hit(regRd, regAddr, OFS_TIME_W0);
  assign timeHiWr = hit(regWr, regAddr, OFS_TIME_W3);
  assign phaseHi  = phaseSum[SUM_W-1:16];
  assign phaseLo  = phaseSum[15:0];

  // carry out of the 33-bit sum is the rollover
  assign sumWide = {1'b0, phaseSum} + {1'b0, rateStep};

  // rate step and its staging half
  always_comb begin
    next_rateStep        = rateStep;
    next_rateStepLowHold = rateStepLowHold;
    if (hit(regWr, regAddr, OFS_RATE_LO)) begin
      next_rateStepLowHold = regWrData;
    end else if (rateHiWr) begin
      next_rateStep = {regWrData, rateStepLowHold};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rateStep        <= RATE_RESET;
      rateStepLowHold <= WORD_RESET;
    end else begin
      rateStep        <= next_rateStep;
      rateStepLowHold <= next_rateStepLowHold;
    end
  end

  // phase sum; a software load replaces that cycle's addition
  always_comb begin
    next_phaseSum          = sumWide[SUM_W-1:0];
    next_overflowPulse     = sumWide[SUM_W];
    next_phaseSumLowHold   = phaseSumLowHold;
    next_phaseSumHighLatch = phaseSumHighLatch;
    if (accLoWr) begin
      next_phaseSumLowHold = regWrData;
    end else if (accHiWr) begin
      next_phaseSum      = {regWrData, phaseSumLowHold};
      next_overflowPulse = 1'b0;
    end
    if (accLoRd) begin
      next_phaseSumHighLatch = phaseHi;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      phaseSum          <= SUM_RESET;
      overflowPulse     <= 1'b0;
      phaseSumLowHold   <= WORD_RESET;
      phaseSumHighLatch <= WORD_RESET;
    end else begin
      phaseSum          <= next_phaseSum;
      overflowPulse     <= next_overflowPulse;
      phaseSumLowHold   <= next_phaseSumLowHold;
      phaseSumHighLatch <= next_phaseSumHighLatch;
    end
  end

  // local time staging words 0..2, committed by the word3 write
  always_comb begin
    next_timeWordHold = timeWordHold;
    if (hit(regWr, regAddr, OFS_TIME_W0)) begin
      next_timeWordHold[15:0] = regWrData;
    end else if (hit(regWr, regAddr, OFS_TIME_W1)) begin
      next_timeWordHold[31:16] = regWrData;
    end else if (hit(regWr, regAddr, OFS_TIME_W2)) begin
      next_timeWordHold[47:32] = regWrData;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      timeWordHold <= LATCH_RESET;
    end else begin
      timeWordHold <= next_timeWordHold;
    end
  end

  // the registered pulse drives the counter, one cycle after the carry
  pca_time_counter pca_time_counter_inst (
    .clk        (clk),
    .srst       (srst),
    .countUp    (overflowPulse),
    .loadEn     (timeHiWr),
    .loadValue  ({regWrData, timeWordHold}),
    .captureEn  (timeLoRd),
    .count      (localTime),
    .upperLatch (timeUpper)
  );

  // read data valid only in the cycle after the strobe, zero otherwise
  always_comb begin
    next_regRdData = READ_UNMAPPED;
    if (regRd) begin
      if (regAddr == OFS_RATE_LO) begin
        next_regRdData = rateStep[15:0];
      end else if (regAddr == OFS_RATE_HI) begin
        next_regRdData = rateStep[SUM_W-1:16];
      end else if (regAddr == OFS_SUM_LO) begin
        next_regRdData = phaseLo;
      end else if (regAddr == OFS_SUM_HI) begin
        next_regRdData = phaseSumHighLatch;
      end else if (regAddr == OFS_TIME_W0) begin
        next_regRdData = localTime[15:0];
      end else if (regAddr == OFS_TIME_W1) begin
        next_regRdData = timeUpper[15:0];
      end else if (regAddr == OFS_TIME_W2) begin
        next_regRdData = timeUpper[31:16];
      end else if (regAddr == OFS_TIME_W3) begin
        next_regRdData = timeUpper[47:32];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      regRdData  <= WORD_RESET;
      checkReady <= 1'b0;
    end else begin
      regRdData  <= next_regRdData;
      checkReady <= 1'b1;
    end
  end

  sum_add_a: assert property (@(posedge clk) disable iff (srst)
    checkReady && !accHiWr |=> phaseSum == $past(phaseSum) + $past(rateStep))
    else $error("phase sum did not add the rate step");

  ovf_carry_a: assert property (@(posedge clk) disable iff (srst)
    checkReady && !accHiWr
      |=> overflowPulse == ($past(phaseSum) > ~$past(rateStep)))
    else $error("overflow pulse does not match the carry");

  ovf_time_a: assert property (@(posedge clk) disable iff (srst)
    overflowPulse && !timeHiWr |=> localTime == $past(localTime) + TIME_STEP)
    else $error("overflow did not advance local time");

  lo_read_a: assert property (@(posedge clk) disable iff (srst)
    accLoRd |=> regRdData == $past(phaseLo))
    else $error("low word read wrong bits");

  hi_latch_a: assert property (@(posedge clk) disable iff (srst)
    accLoRd ##1 accHiRd |=> regRdData == $past(phaseHi, 2))
    else $error("high word read not the latched value");

  sum_load_a: assert property (@(posedge clk) disable iff (srst)
    accHiWr |=> phaseSum == {$past(regWrData), $past(phaseSumLowHold)}
      && !overflowPulse)
    else $error("phase sum not loaded by high write");

  rate_load_a: assert property (@(posedge clk) disable iff (srst)
    rateHiWr |=> rateStep == {$past(regWrData), $past(rateStepLowHold)})
    else $error("rate step not loaded by high write");

  rate_keep_a: assert property (@(posedge clk) disable iff (srst)
    checkReady && !rateHiWr |=> $stable(rateStep))
    else $error("rate step changed without high write");

  time_read_a: assert property (@(posedge clk) disable iff (srst)
    timeLoRd ##1 hit(regRd, regAddr, OFS_TIME_W3)
      |=> regRdData == $past(localTime[63:48], 2))
    else $error("word3 read not from the word0 latch");

  rollover_c: cover property (@(posedge clk) disable iff (srst)
    overflowPulse ##1 overflowPulse);
  sum_write_c: cover property (@(posedge clk) disable iff (srst)
    accLoWr ##[1:4] accHiWr);
  time_load_c: cover property (@(posedge clk) disable iff (srst)
    timeHiWr && overflowPulse);
endmodule // pca_clock_accumulator
`default_nettype wire

// [sim/ptp_clock_accumulator_test.sv]
`timescale 1ns/100ps
`default_nettype none
module ptp_clock_accumulator_test;
  import pca_pkg::*;
  logic              clk       = 1'b0;
  logic              srst      = 1'b1;
  logic [ADDR_W-1:0] regAddr   = '0;
  logic [DATA_W-1:0] regWrData = '0;
  logic              regWr     = 1'b0;
  logic              regRd     = 1'b0;
  logic [DATA_W-1:0] regRdData;
  logic              overflowPulse;
  logic [TIME_W-1:0] localTime;
  logic [TIME_W-1:0] t0;
  logic [DATA_W-1:0] tw [4] = '{16'h1111, 16'h2222, 16'h3333, 16'h4444};
  int                errCount  = 0;
  int                numChecks = 0;
  int                ovfCount  = 0;
  int                o0;

  always #2.5 clk = ~clk;

  pca_clock_accumulator pca_clock_accumulator_inst (
    .clk           (clk),
    .srst          (srst),
    .regAddr       (regAddr),
    .regWrData     (regWrData),
    .regWr         (regWr),
    .regRd         (regRd),
    .regRdData     (regRdData),
    .overflowPulse (overflowPulse),
    .localTime     (localTime)
  );

  always @(posedge clk) begin
    if (overflowPulse === 1'b1) begin
      ovfCount <= ovfCount + 1;
    end
  end

  task automatic endSim();
    $display("checks %0d mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk16(input string nm, input logic [15:0] exp,
                       input logic [15:0] got);
    numChecks++;
    if (got !== exp) begin
      errCount++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk64(input string nm, input logic [63:0] exp,
                       input logic [63:0] got);
    numChecks++;
    if (got !== exp) begin
      errCount++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wrReg(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge clk);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rdChk(input logic [ADDR_W-1:0] a, input logic [15:0] exp,
                       input string nm);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk16(nm, exp, regRdData);
  endtask

  // two reads with no gap: the second strobe follows the first directly
  task automatic rdPair(input logic [ADDR_W-1:0] a0, input logic [15:0] e0,
                        input logic [ADDR_W-1:0] a1, input logic [15:0] e1,
                        input string nm);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a0;
    @(posedge clk);
    regAddr <= a1;
    #1 chk16({nm, " first"}, e0, regRdData);
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk16({nm, " second"}, e1, regRdData);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    $display("timeout reached");
    errCount++;
    endSim();
  end

  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    for (int a = 4; a <= 18; a += 2) begin
      rdChk(a[7:0], WORD_RESET, "reset word");
    end
    rdChk(8'h20, READ_UNMAPPED, "unmapped read");
    repeat (20) @(posedge clk);
    #1 chk64("idle time", TIME_RESET, localTime);
    $display("test reset done");

    wrReg(8'h20, 16'hFFFF);
    wrReg(OFS_SUM_LO, 16'h5678);
    wrReg(OFS_SUM_HI, 16'h1234);
    wrReg(OFS_SUM_LO, 16'hAAAA);
    rdChk(OFS_SUM_LO, 16'h5678, "sum low held");
    rdChk(OFS_SUM_HI, 16'h1234, "sum high");
    @(posedge clk);
    #1 chk16("read idle", 16'h0000, regRdData);
    wrReg(OFS_RATE_LO, 16'h0001);
    rdChk(OFS_RATE_LO, 16'h0000, "rate staged");
    wrReg(OFS_RATE_HI, 16'h0001);
    rdChk(OFS_RATE_HI, 16'h0001, "rate high");
    rdChk(OFS_RATE_LO, 16'h0001, "rate low");
    $display("test load done");

    // sum restarts at zero, one step per cycle in both halves
    wrReg(OFS_SUM_LO, 16'h0000);
    wrReg(OFS_SUM_HI, 16'h0000);
    // live high is already 0002 when the latched 0001 is read back
    rdPair(OFS_SUM_LO, 16'h0001, OFS_SUM_HI, 16'h0001,
           "sum latch");
    $display("test latch done");

    wrReg(OFS_RATE_LO, 16'h0000);
    wrReg(OFS_RATE_HI, 16'h4000);
    repeat (4) @(posedge clk);
    #1 t0 = localTime;
    o0 = ovfCount;
    // quarter-range step: exactly one carry per four cycles
    repeat (40) @(posedge clk);
    #1 chk64("pulses", 64'd10, 64'(ovfCount - o0));
    chk64("time advance", t0 + 64'd10, localTime);
    $display("test overflow done");

    wrReg(OFS_RATE_HI, 16'h0000);
    repeat (4) @(posedge clk);
    #1 t0 = localTime;
    for (int i = 0; i < 3; i++) begin
      wrReg(OFS_TIME_W0 + 8'(2 * i), tw[i]);
    end
    #1 chk64("time held", t0, localTime);
    wrReg(OFS_TIME_W3, tw[3]);
    #1 chk64("time load", 64'h4444_3333_2222_1111, localTime);
    for (int i = 0; i < 4; i++) begin
      rdChk(OFS_TIME_W0 + 8'(2 * i), tw[i], "time word");
    end
    rdPair(OFS_TIME_W0, tw[0], OFS_TIME_W3, tw[3], "time pair");
    // reload only the top word; the latch must keep the earlier upper bits
    wrReg(OFS_TIME_W3, 16'h5555);
    #1 chk64("time reload", 64'h5555_3333_2222_1111, localTime);
    rdChk(OFS_TIME_W3, tw[3], "word3 latched");
    $display("test time done");

    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1 chk64("time after reset", TIME_RESET, localTime);
    rdChk(OFS_SUM_HI, WORD_RESET, "sum after reset");
    $display("test second reset done");
    endSim();
  end
endmodule // ptp_clock_accumulator_test
`default_nettype wire
